/* File: hw/dcb_kchar_check.v */
`timescale 1ns/1ns
`include "dcb_map.vh"

module dcb_kchar_check (
    char_byte,
    k_valid,
    k_err_code
);
    input wire [7:0] char_byte;
    output reg k_valid;
    output reg k_err_code;

    always @* begin
        k_err_code = (char_byte == `DCB_ERR_BYTE);
        case (char_byte)
            8'hF7, 8'hFB, 8'hFD, 8'hFE: begin
                k_valid = 1'b1;
            end
            default: begin
                k_valid = (char_byte[4:0] == 5'h1C);
            end
        endcase
    end
endmodule

/* File: hw/dcb_line_codec.v */
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "dcb_map.vh"


module dcb_line_codec (
    hclk,
    hresetn,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hreadyout,
    hresp,
    hrdata,
    enc_ena,
    enc_kin,
    enc_byte,
    enc_sym,
    enc_sym_valid,
    enc_kerr,
    dec_sym_valid,
    dec_sym,
    dec_byte,
    dec_kout,
    dec_byte_valid,
    dec_kerr,
    dec_rderr
);
    input wire hclk;
    input wire hresetn;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output reg hreadyout;
    output reg hresp;
    output reg [31:0] hrdata;
    input wire enc_ena;
    input wire enc_kin;
    input wire [7:0] enc_byte;
    output reg [9:0] enc_sym;
    output reg enc_sym_valid;
    output reg enc_kerr;
    input wire dec_sym_valid;
    input wire [9:0] dec_sym;
    output reg [7:0] dec_byte;
    output reg dec_kout;
    output reg dec_byte_valid;
    output reg dec_kerr;
    output reg dec_rderr;

    ////////////////////////////////////////////////////////////////////////////
    // code tables, printed order: a (or f) in the top bit

    function [5:0] tab6;
        input [4:0] x;
        begin
            case (x)
                5'h00: tab6 = 6'h27;
                5'h01: tab6 = 6'h1D;
                5'h02: tab6 = 6'h2D;
                5'h03: tab6 = 6'h31;
                5'h04: tab6 = 6'h35;
                5'h05: tab6 = 6'h29;
                5'h06: tab6 = 6'h19;
                5'h07: tab6 = 6'h38;
                5'h08: tab6 = 6'h39;
                5'h09: tab6 = 6'h25;
                5'h0A: tab6 = 6'h15;
                5'h0B: tab6 = 6'h34;
                5'h0C: tab6 = 6'h0D;
                5'h0D: tab6 = 6'h2C;
                5'h0E: tab6 = 6'h1C;
                5'h0F: tab6 = 6'h17;
                5'h10: tab6 = 6'h1B;
                5'h11: tab6 = 6'h23;
                5'h12: tab6 = 6'h13;
                5'h13: tab6 = 6'h32;
                5'h14: tab6 = 6'h0B;
                5'h15: tab6 = 6'h2A;
                5'h16: tab6 = 6'h1A;
                5'h17: tab6 = 6'h3A;
                5'h18: tab6 = 6'h33;
                5'h19: tab6 = 6'h26;
                5'h1A: tab6 = 6'h16;
                5'h1B: tab6 = 6'h36;
                5'h1C: tab6 = 6'h0E;
                5'h1D: tab6 = 6'h2E;
                5'h1E: tab6 = 6'h1E;
                default: tab6 = 6'h2B;
            endcase
        end
    endfunction

    function [3:0] tab4;
        input [2:0] y;
        begin
            case (y)
                3'h0: tab4 = 4'hB;
                3'h1: tab4 = 4'h9;
                3'h2: tab4 = 4'h5;
                3'h3: tab4 = 4'hC;
                3'h4: tab4 = 4'hD;
                3'h5: tab4 = 4'hA;
                3'h6: tab4 = 4'h6;
                default: tab4 = 4'hE;
            endcase
        end
    endfunction

    function [2:0] pop6;
        input [5:0] v;
        begin
            pop6 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]}
                + {2'h0, v[3]} + {2'h0, v[4]} + {2'h0, v[5]};
        end
    endfunction

    // lsb-first line order: a sits at bit 0 of the symbol bus
    function [9:0] rev10;
        input [9:0] v;
        integer n;
        begin
            for (n = 0; n < 10; n = n + 1) begin
                rev10[n] = v[9 - n];
            end
        end
    endfunction

    // four-bit subblock for a given disparity after the six-bit subblock
    function [3:0] enc4;
        input [2:0] y;
        input k;
        input rdm;
        input a7;
        reg [3:0] t;
        reg flip;
        begin
            t = a7 ? `DCB_A7_FOUR : tab4(y);
            flip = (pop6({2'h0, t}) != 3'h2) || (t == `DCB_P3_FOUR);
            if (rdm) begin
                enc4 = flip ? ~t : t;
            end else begin
                enc4 = (k && !flip) ? ~t : t;
            end
        end
    endfunction

    // whole word; x.y naming with x the five-bit and y the three-bit group
    function [9:0] enc_word;
        input [7:0] b;
        input k;
        input rd;
        reg [4:0] x;
        reg [2:0] y;
        reg [5:0] t6;
        reg rdm;
        reg a7;
        begin
            x = b[4:0];
            y = b[7:5];
            t6 = (k && x == 5'h1C) ? `DCB_K28_SIX : tab6(x);
            rdm = (pop6(t6) != 3'h3) ? ~rd : rd;
            a7 = (y == 3'h7) && (k || (!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14))
                || (rdm && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
            if (rd && (pop6(t6) != 3'h3 || t6 == `DCB_D7_SIX)) begin
                enc_word[9:4] = ~t6;
            end else begin
                enc_word[9:4] = t6;
            end
            enc_word[3:0] = enc4(y, k, rdm, a7);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    reg ctrl_idle_reg;
    reg [2:0] err_flag_reg;
    reg [`DCB_CNT_W-1:0] kerr_cnt_reg;
    reg [`DCB_CNT_W-1:0] rderr_cnt_reg;
    reg enc_rd_reg;
    reg dec_rd_reg;
    reg wr_pend_reg;
    reg [`DCB_ADDR_W-1:0] wr_addr_reg;
    reg [31:0] rd_word;
    wire addr_phase;

    assign addr_phase = hsel && htrans[1] && hready;

    always @* begin
        case (haddr[`DCB_ADDR_W-1:0])
            `DCB_CTRL_OFS: begin
                rd_word = {31'h0, ctrl_idle_reg};
            end
            `DCB_STATUS_OFS: begin
                rd_word = {30'h0, dec_rd_reg, enc_rd_reg};
            end
            `DCB_ERRFLAG_OFS: begin
                rd_word = {29'h0, err_flag_reg};
            end
            `DCB_ERRCNT_OFS: begin
                rd_word = {rderr_cnt_reg, kerr_cnt_reg};
            end
            default: begin
                rd_word = 32'h0;
            end
        endcase
    end

    // zero wait states: read data is prepared during the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            ctrl_idle_reg <= `DCB_CTRL_RST;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_reg <= haddr[`DCB_ADDR_W-1:0];
            end
            if (addr_phase && !hwrite) begin
                hrdata <= rd_word;
            end
            if (wr_pend_reg && wr_addr_reg == `DCB_CTRL_OFS) begin
                ctrl_idle_reg <= hwdata[`DCB_CTRL_IDLE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // encoder

    wire k_valid;
    wire k_err_code;
    wire enc_rd_after;
    reg [9:0] enc_word_next;
    reg enc_go;
    reg enc_kerr_next;

    dcb_kchar_check u_kchk (
        .char_byte(enc_byte),
        .k_valid(k_valid),
        .k_err_code(k_err_code)
    );

    always @* begin
        enc_go = 1'b0;
        enc_kerr_next = 1'b0;
        enc_word_next = enc_word(`DCB_IDLE_BYTE, 1'b1, enc_rd_reg);
        if (enc_ena) begin
            enc_go = 1'b1;
            if (enc_kin && k_err_code) begin
                enc_word_next = enc_rd_reg ? `DCB_ERR_WORD_POS : `DCB_ERR_WORD_NEG;
            end else if (enc_kin && !k_valid) begin
                enc_kerr_next = 1'b1;
            end else begin
                enc_word_next = enc_word(enc_byte, enc_kin, enc_rd_reg);
            end
        end else if (ctrl_idle_reg) begin
            enc_go = 1'b1;
        end
    end

    // the checker also yields the disparity left by the outgoing word
    dcb_rd_checker u_enc_rd (
        .word(enc_word_next),
        .rd_in(enc_rd_reg),
        .rd_err(),
        .rd_out(enc_rd_after)
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enc_sym <= 10'h000;
            enc_sym_valid <= 1'b0;
            enc_kerr <= 1'b0;
            enc_rd_reg <= `DCB_RD_RST;
        end else begin
            enc_sym_valid <= enc_go;
            enc_kerr <= enc_kerr_next;
            if (enc_go) begin
                enc_sym <= rev10(enc_word_next);
                enc_rd_reg <= enc_rd_after;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoder

    reg [9:0] rx_word;
    reg [4:0] rx_x;
    reg [2:0] rx_y;
    reg rx_k;
    reg rx_k28;
    reg rx_legal;
    wire rx_rderr;
    wire dec_rd_after;
    integer i;
    integer r;

    always @* begin
        rx_word = rev10(dec_sym);
        rx_x = 5'h00;
        rx_y = 3'h0;
        rx_k28 = (rx_word[9:4] == `DCB_K28_SIX) || (rx_word[9:4] == ~`DCB_K28_SIX);
        for (i = 0; i < 32; i = i + 1) begin
            // a balanced group other than D7 has one form only; its inverse is another x
            if (rx_word[9:4] == tab6(i[4:0]) || (rx_word[9:4] == ~tab6(i[4:0])
                && (pop6(tab6(i[4:0])) != 3'h3 || tab6(i[4:0]) == `DCB_D7_SIX))) begin
                rx_x = i[4:0];
            end
        end
        if (rx_k28) begin
            rx_x = 5'h1C;
        end
        // control four-bit groups are ambiguous unless the six-bit form picks rd
        for (i = 0; i < 8; i = i + 1) begin
            for (r = 0; r < 2; r = r + 1) begin
                if (rx_word[3:0] == enc4(i[2:0], rx_k28, r[0], 1'b0)
                    && (!rx_k28 || r[0] == (rx_word[9:4] == `DCB_K28_SIX))) begin
                    rx_y = i[2:0];
                end
            end
        end
        if (rx_word[3:0] == `DCB_A7_FOUR || rx_word[3:0] == ~`DCB_A7_FOUR) begin
            rx_y = 3'h7;
        end
        rx_k = rx_k28 || ((rx_word[3:0] == `DCB_A7_FOUR
            || rx_word[3:0] == ~`DCB_A7_FOUR) && (rx_x == 5'h17 || rx_x == 5'h1B
            || rx_x == 5'h1D || rx_x == 5'h1E));
        // exact legality: the word must re-encode from one of the two disparities
        rx_legal = (enc_word({rx_y, rx_x}, rx_k, 1'b0) == rx_word)
            || (enc_word({rx_y, rx_x}, rx_k, 1'b1) == rx_word);
    end

    dcb_rd_checker u_dec_rd (
        .word(rx_word),
        .rd_in(dec_rd_reg),
        .rd_err(rx_rderr),
        .rd_out(dec_rd_after)
    );

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dec_byte <= 8'h00;
            dec_kout <= 1'b0;
            dec_byte_valid <= 1'b0;
            dec_kerr <= 1'b0;
            dec_rderr <= 1'b0;
            dec_rd_reg <= `DCB_RD_RST;
        end else begin
            dec_byte_valid <= dec_sym_valid;
            if (dec_sym_valid) begin
                // byte and both flags leave on the same edge
                dec_byte <= rx_legal ? {rx_y, rx_x} : `DCB_IDLE_BYTE;
                dec_kout <= rx_legal ? rx_k : 1'b1;
                dec_kerr <= !rx_legal;
                dec_rderr <= rx_rderr;
                dec_rd_reg <= dec_rd_after;
            end else begin
                dec_kerr <= 1'b0;
                dec_rderr <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky flags and counters; a new event wins over a clear

    wire [2:0] err_evt;

    assign err_evt = {dec_rderr & dec_byte_valid, dec_kerr & dec_byte_valid, enc_kerr};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_flag_reg <= `DCB_EF_RST;
            kerr_cnt_reg <= 16'h0000;
            rderr_cnt_reg <= 16'h0000;
        end else begin
            if (wr_pend_reg && wr_addr_reg == `DCB_ERRFLAG_OFS) begin
                err_flag_reg <= (err_flag_reg & ~hwdata[2:0]) | err_evt;
            end else begin
                err_flag_reg <= err_flag_reg | err_evt;
            end
            // counters saturate so a long burst cannot wrap to a small value
            if (err_evt[`DCB_EF_DEC_KERR_BIT] && kerr_cnt_reg != 16'hFFFF) begin
                kerr_cnt_reg <= kerr_cnt_reg + 16'h0001;
            end
            if (err_evt[`DCB_EF_DEC_RDERR_BIT] && rderr_cnt_reg != 16'hFFFF) begin
                rderr_cnt_reg <= rderr_cnt_reg + 16'h0001;
            end
        end
    end
endmodule

/* File: hw/dcb_map.vh */
`ifndef DCB_MAP_VH
`define DCB_MAP_VH

// register byte offsets
`define DCB_CTRL_OFS 8'h00
`define DCB_STATUS_OFS 8'h04
`define DCB_ERRFLAG_OFS 8'h08
`define DCB_ERRCNT_OFS 8'h0C
`define DCB_ADDR_W 8

// control fields
`define DCB_CTRL_IDLE_BIT 0
`define DCB_CTRL_RST 1'h0

// status fields
`define DCB_STAT_ENC_RD_BIT 0
`define DCB_STAT_DEC_RD_BIT 1

// sticky error flags, write one to clear
`define DCB_EF_ENC_KERR_BIT 0
`define DCB_EF_DEC_KERR_BIT 1
`define DCB_EF_DEC_RDERR_BIT 2
`define DCB_EF_RST 3'h0

// error counters
`define DCB_CNT_KERR_LSB 0
`define DCB_CNT_RDERR_LSB 16
`define DCB_CNT_W 16

// character codes
`define DCB_IDLE_BYTE 8'hBC
`define DCB_ERR_BYTE 8'hFF
`define DCB_ERR_WORD_NEG 10'h0F1
`define DCB_ERR_WORD_POS 10'h30E
`define DCB_K28_SIX 6'h0F
`define DCB_D7_SIX 6'h38
`define DCB_P3_FOUR 4'hC
`define DCB_A7_FOUR 4'h7

// running disparity after reset: negative
`define DCB_RD_RST 1'h0

`endif

/* File: hw/dcb_rd_checker.v */
`timescale 1ns/1ns
`include "dcb_map.vh"

module dcb_rd_checker (
    word,
    rd_in,
    rd_err,
    rd_out
);
    // word in printed order: a at bit 9 down to j at bit 0
    input wire [9:0] word;
    input wire rd_in;
    output reg rd_err;
    output reg rd_out;

    reg [2:0] ones6;
    reg [2:0] ones4;
    reg rd_mid;
    integer i;

    always @* begin
        ones6 = 3'h0;
        ones4 = 3'h0;
        for (i = 4; i < 10; i = i + 1) begin
            ones6 = ones6 + {2'h0, word[i]};
        end
        for (i = 0; i < 4; i = i + 1) begin
            ones4 = ones4 + {2'h0, word[i]};
        end
        rd_err = 1'b0;
        if (rd_in && (ones6 > 3'h3 || word[9:4] == `DCB_D7_SIX)) begin
            rd_err = 1'b1;
        end
        if (!rd_in && (ones6 < 3'h3 || word[9:4] == ~`DCB_D7_SIX)) begin
            rd_err = 1'b1;
        end
        // 000111 ends positive and 111000 ends negative
        if (ones6 != 3'h3) begin
            rd_mid = (ones6 > 3'h3);
        end else if (word[9:4] == `DCB_D7_SIX || word[9:4] == ~`DCB_D7_SIX) begin
            rd_mid = (word[9:4] == ~`DCB_D7_SIX);
        end else begin
            rd_mid = rd_in;
        end
        if (rd_mid && (ones4 > 3'h2 || word[3:0] == `DCB_P3_FOUR)) begin
            rd_err = 1'b1;
        end
        if (!rd_mid && (ones4 < 3'h2 || word[3:0] == ~`DCB_P3_FOUR)) begin
            rd_err = 1'b1;
        end
        if (ones4 != 3'h2) begin
            rd_out = (ones4 > 3'h2);
        end else if (word[3:0] == `DCB_P3_FOUR || word[3:0] == ~`DCB_P3_FOUR) begin
            rd_out = (word[3:0] == ~`DCB_P3_FOUR);
        end else begin
            rd_out = rd_mid;
        end
    end
endmodule

/* File: sim/dcb_far_end.sv */
`timescale 1ns/1ns
module dcb_far_end (
    input wire hclk,
    input wire hresetn,
    input wire slow,
    input wire [9:0] tx_sym,
    input wire tx_valid,
    input wire [9:0] inj_sym,
    input wire inj_valid,
    output logic [9:0] rx_sym,
    output logic rx_valid
);
    logic [9:0] line, d_reg, last;
    logic dv_reg;
    ////////////////////////////////////////
    // serial path ships bit 0 first, so words arrive in the same bit order
    assign line = inj_valid ? inj_sym : tx_sym;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d_reg <= 10'h000;
            dv_reg <= 1'b0;
            last <= 10'h000;
        end else begin
            d_reg <= line;
            dv_reg <= inj_valid | tx_valid;
            if (rx_valid) last <= rx_sym;
        end
    end
    // between words the line is not held: show the inverse, never a stale match
    assign rx_valid = slow ? dv_reg : (inj_valid | tx_valid);
    assign rx_sym = !rx_valid ? ~last : slow ? d_reg : line;
endmodule

/* File: sim/dcb_line_codec_props.sv */
`timescale 1ns/1ns
module dcb_line_codec_props (
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire enc_ena,
    input wire enc_kin,
    input wire [7:0] enc_byte,
    input wire [9:0] enc_sym,
    input wire enc_sym_valid,
    input wire enc_kerr,
    input wire dec_sym_valid,
    input wire [7:0] dec_byte,
    input wire dec_kout,
    input wire dec_byte_valid,
    input wire dec_kerr,
    input wire dec_rderr
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire k_ok = enc_byte[4:0] == 5'h1C || enc_byte == 8'hF7 || enc_byte == 8'hFB
        || enc_byte == 8'hFD || enc_byte == 8'hFE;
    ////////////////////////////////////////
    sequence s_err_req;
        enc_ena && enc_kin && enc_byte == 8'hFF;
    endsequence
    sequence s_bad_k;
        enc_ena && enc_kin && !k_ok && enc_byte != 8'hFF;
    endsequence
    sequence s_comma;
        enc_sym == 10'h17C || enc_sym == 10'h283;
    endsequence
    property p_err_word;
        s_err_req |=> enc_sym_valid && (enc_sym == 10'h23C || enc_sym == 10'h1C3);
    endproperty
    a_err_word: assert property (p_err_word) else $error("bad error word");
    property p_err_flag;
        s_err_req |=> !enc_kerr;
    endproperty
    a_err_flag: assert property (p_err_flag) else $error("kerr on error code");
    property p_enc_take;
        enc_ena |=> enc_sym_valid;
    endproperty
    a_enc_take: assert property (p_enc_take) else $error("no symbol");
    property p_bad_k;
        s_bad_k |=> enc_kerr;
    endproperty
    a_bad_k: assert property (p_bad_k) else $error("kerr missing");
    property p_data_k;
        enc_ena && !enc_kin |=> !enc_kerr;
    endproperty
    a_data_k: assert property (p_data_k) else $error("kerr on data");
    property p_kerr_comma;
        enc_kerr |-> enc_sym_valid ##0 s_comma;
    endproperty
    a_kerr_comma: assert property (p_kerr_comma) else $error("bad k not comma");
    property p_dec_take;
        dec_sym_valid |=> dec_byte_valid;
    endproperty
    a_dec_take: assert property (p_dec_take) else $error("no byte");
    property p_dec_flags;
        dec_kerr || dec_rderr |-> dec_byte_valid;
    endproperty
    a_dec_flags: assert property (p_dec_flags) else $error("flag alone");
    property p_dec_illegal;
        dec_kerr |-> dec_byte == 8'hBC && dec_kout;
    endproperty
    a_dec_illegal: assert property (p_dec_illegal) else $error("illegal not idle");
    property p_dec_quiet;
        !dec_sym_valid |=> !dec_byte_valid && !dec_kerr && !dec_rderr;
    endproperty
    a_dec_quiet: assert property (p_dec_quiet) else $error("output w/o input");
    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("bus not okay");
endmodule
bind dcb_line_codec dcb_line_codec_props u_dcb_line_codec_props (.hclk(hclk),
    .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .enc_ena(enc_ena),
    .enc_kin(enc_kin), .enc_byte(enc_byte), .enc_sym(enc_sym), .enc_sym_valid(enc_sym_valid),
    .enc_kerr(enc_kerr), .dec_sym_valid(dec_sym_valid), .dec_byte(dec_byte),
    .dec_kout(dec_kout), .dec_byte_valid(dec_byte_valid), .dec_kerr(dec_kerr),
    .dec_rderr(dec_rderr));

/* File: sim/dcb_line_codec_test.sv */
`timescale 1ns/1ns
module dcb_line_codec_test;
    logic hclk, hresetn, hsel, hwrite, enc_ena, enc_kin, slow, inj_valid, erd;
    logic [31:0] haddr, hwdata, rdat;
    logic [1:0] htrans, ee;
    logic [7:0] enc_byte;
    logic [9:0] inj_sym;
    logic [10:0] de;
    logic [10:0] dq[$];
    logic [1:0] eq[$];
    integer n_mismatch, samples_checked, cyc, n_idle, c;
    wire hreadyout, hresp, enc_sym_valid, enc_kerr, dec_sym_valid, dec_kout;
    wire dec_byte_valid, dec_kerr, dec_rderr;
    wire [31:0] hrdata;
    wire [9:0] enc_sym, dec_sym;
    wire [7:0] dec_byte;
    dcb_line_codec u_dcb_line_codec (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .enc_ena(enc_ena), .enc_kin(enc_kin), .enc_byte(enc_byte), .enc_sym(enc_sym),
        .enc_sym_valid(enc_sym_valid), .enc_kerr(enc_kerr), .dec_sym_valid(dec_sym_valid),
        .dec_sym(dec_sym), .dec_byte(dec_byte), .dec_kout(dec_kout),
        .dec_byte_valid(dec_byte_valid), .dec_kerr(dec_kerr), .dec_rderr(dec_rderr));
    dcb_far_end u_dcb_far_end (.hclk(hclk), .hresetn(hresetn), .slow(slow),
        .tx_sym(enc_sym), .tx_valid(enc_sym_valid), .inj_sym(inj_sym),
        .inj_valid(inj_valid), .rx_sym(dec_sym), .rx_valid(dec_sym_valid));
    ////////////////////////////////////////
    task cmp(input [31:0] got, input [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // zero wait states are promised, but the master still waits on hready
    task ahb(input w, input [7:0] a, input [31:0] d);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    task ahb_rd(input [7:0] a, input [31:0] e);
        ahb(0, a, 32'h0);
        cmp(rdat, e);
    endtask
    task send(input k, input [7:0] b);
        logic ok, bad;
        ok = b[4:0] == 5'h1C || b == 8'hF7 || b == 8'hFB || b == 8'hFD || b == 8'hFE;
        bad = k && !ok && b != 8'hFF;
        enc_ena <= 1; enc_kin <= k; enc_byte <= b;
        eq.push_back({2{bad}});
        dq.push_back(!k ? {3'h0, b} : b == 8'hFF ? 11'h5BC : ok ? {3'h1, b} : 11'h1BC);
        @(posedge hclk);
    endtask
    task inj(input [9:0] p, input [10:0] e);
        for (int i = 0; i < 10; i++) inj_sym[i] <= p[9 - i];
        inj_valid <= 1;
        dq.push_back(e);
        @(posedge hclk);
    endtask
    task drain;
        enc_ena <= 0; inj_valid <= 0;
        repeat (8) @(posedge hclk);
        cmp(dq.size() + eq.size(), 0);
    endtask
    ////////////////////////////////////////
    task t_reset;
        cmp({hresp, enc_sym_valid, enc_kerr, dec_byte_valid, dec_kerr, dec_rderr}, 0);
        ahb_rd(8'h04, 32'h0);
        ahb_rd(8'h0C, 32'h0);
        ahb_rd(8'h40, 32'h0);
        $display("test reset done");
    endtask
    task t_inject;
        inj(10'h0FA, 11'h1BC);
        inj(10'h0FA, 11'h3BC);
        inj(10'h305, 11'h1BC);
        inj(10'h305, 11'h3BC);
        inj(10'h313, 11'h263);
        inj(10'h31C, 11'h263);
        inj(10'h000, 11'h7BC);
        drain;
        ahb_rd(8'h08, 32'h6);
        ahb(1, 8'h08, 32'h7);
        ahb_rd(8'h08, 32'h0);
        ahb_rd(8'h0C, 32'h0005_0001);
        ahb_rd(8'h04, 32'h0);
        $display("test inject done");
    endtask
    task t_stream;
        for (int i = 0; i < 256; i++) send(0, i[7:0]);
        for (int i = 0; i < 8; i++) send(1, {i[2:0], 5'h1C});
        send(1, 8'hF7); send(1, 8'hFB); send(1, 8'hFD); send(1, 8'hFE);
        drain;
        slow <= 1;
        send(1, 8'h00);
        send(1, 8'hFF);
        send(0, 8'hFF);
        send(1, 8'hFF);
        drain;
        slow <= 0;
        ahb_rd(8'h08, 32'h3);
        $display("test stream done");
    endtask
    task t_idle;
        n_idle = 0;
        ahb(1, 8'h00, 32'h1);
        repeat (6) @(posedge hclk);
        ahb(1, 8'h00, 32'h0);
        repeat (4) @(posedge hclk);
        cmp(n_idle > 4, 1);
        repeat (4) begin
            @(posedge hclk);
            cmp(enc_sym_valid, 0);
        end
        ahb_rd(8'h00, 32'h0);
        $display("test idle done");
    endtask
    task t_async;
        @(posedge hclk);
        hresetn <= 0;
        #1 cmp({enc_sym, dec_byte}, 0);
        @(posedge hclk);
        hresetn <= 1;
        erd = 0;
        @(posedge hclk);
        ahb_rd(8'h08, 32'h0);
        $display("test async reset done");
    endtask
    ////////////////////////////////////////
    initial begin
        hclk = 0;
        forever #25 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    always @(posedge hclk) begin
        if (enc_sym_valid) begin
            if (eq.size() == 0) n_idle++;
            ee = eq.size() ? eq.pop_front() : 2'h1;
            cmp(enc_kerr, ee[1]);
            if (ee[0]) cmp(enc_sym, erd ? 10'h283 : 10'h17C);
            c = $countones(enc_sym);
            cmp(erd ? c > 5 : c < 5, 0);
            if (c != 5) erd = c > 5;
        end
        if (dec_byte_valid) begin
            de = dq.size() ? dq.pop_front() : 11'h1BC;
            cmp({dec_kerr, dec_rderr, dec_kout, dec_byte}, de);
        end
    end
    initial begin
        {hresetn, hsel, hwrite, enc_ena, enc_kin, slow, inj_valid, erd} = 0;
        haddr = 0; hwdata = 0; htrans = 0; enc_byte = 0; inj_sym = 0;
        n_mismatch = 0; samples_checked = 0; cyc = 0; n_idle = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        t_reset;
        t_inject;
        t_stream;
        t_idle;
        t_async;
        tally_and_finish;
    end
endmodule
